/* design/scg_defs.vh */
// Register map, field layout, reset values and timing constants of the sine/cosine generator.
`ifndef SCG_DEFS_VH
`define SCG_DEFS_VH

// Byte addresses on the register bus.
`define SCG_ADDR_W         6
`define SCG_REG_CTRL       6'h00
`define SCG_REG_SIN_GAIN   6'h04
`define SCG_REG_SIN_BIAS   6'h08
`define SCG_REG_SIN_SHIFT  6'h0c
`define SCG_REG_SIN_RATE   6'h10
`define SCG_REG_COS_GAIN   6'h14
`define SCG_REG_COS_BIAS   6'h18
`define SCG_REG_COS_SHIFT  6'h1c
`define SCG_REG_COS_RATE   6'h20
`define SCG_REG_SHIFT_STAT 6'h24
`define SCG_REG_WAVE       6'h28

// Parameter slots, one per channel: gain, bias, local shift, slew rate.
`define SCG_SLOT_GAIN      2'h0
`define SCG_SLOT_BIAS      2'h1
`define SCG_SLOT_SHIFT     2'h2
`define SCG_SLOT_RATE      2'h3

// Control register fields.
`define SCG_CTRL_MODE_LSB  0
`define SCG_CTRL_SRC_BIT   2
`define SCG_CTRL_PP_LSB    8
`define SCG_CTRL_CNT_LSB   16
`define SCG_MODE_ENC       2'h0
`define SCG_MODE_RES       2'h1
`define SCG_MODE_ARB       2'h2
`define SCG_MODE_RST       2'h0
`define SCG_PP_RST         7'h01
`define SCG_PP_MAX         7'h40
`define SCG_CNT_RST        4'h2
`define SCG_PRM_RST        16'h0000

// Angle and waveform arithmetic.
`define SCG_QUARTER        16'h4000
`define SCG_HALF           16'h8000
`define SCG_SIN_K0         16'h6333
`define SCG_SIN_K1         16'h1ccd
`define SCG_Q15_POS        18'sh07fff
`define SCG_Q15_NEG        18'sh38000

// Timing: phase slew accumulates rate * 1000 per clock against 360 * clock rate.
`define SCG_CLK_PERIOD_NS  40'd5
`define SCG_CLK_HZ         (40'd1000000000 / `SCG_CLK_PERIOD_NS)
`define SCG_DEG_PER_REV    40'd360
`define SCG_RATE_FULL_DPS  26'd1000
`define SCG_SLEW_THRESH    (`SCG_DEG_PER_REV * `SCG_CLK_HZ)

`endif

/* design/scg_sincos_gen.v */
// Angle-synchronous sine/cosine generator with an Avalon-MM register slave.
//
// Overview of operation
// [RULE1] Two channels: sine and cosine, quarter apart.
// [RULE2] Resolver mode: envelopes multiply external carrier.
// [RULE3] Unsigned 16-bit gain, 0.0 to 1.0.
// [RULE4] Encoder mode adds signed 16-bit bias.
// [RULE5] Output clamped to -1.0 .. +1.0.
// [RULE6] Signed 16-bit local shift, +-180 degrees.
// [RULE7] Applied shift slews toward new setting.
// [RULE8] Rate 0..1000 deg/s; zero jumps at once.
// [RULE9] Software should program nonzero slew rate.
// [RULE10] Pole pairs up to 64 multiply frequency.
// [RULE11] Waveform follows rotor angle, not time.
// [RULE12] Direct source ignores global shift.
// [RULE13] Shifted source adds global to local.
// [RULE14] One global shift moves all channels together.
// [RULE15] Resolver uses both channels, ignores count.
// [RULE16] Arbitrary mode drives one generator only.
// [RULE17] Angle sum wraps modulo one revolution.
// [RULE18] Resolver mode applies zero bias.
`timescale 1ns/1ps
`include "scg_defs.vh"

module scg_chan #(
  parameter [39:0] SLEW_THRESH = `SCG_SLEW_THRESH
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        resetn_in,
  // Angle sources
  input  wire [15:0] rotor_angle_in,
  input  wire [15:0] global_angle_shift_in,
  input  wire        use_global_in,
  // Configuration
  input  wire [6:0]  pole_pairs_in,
  input  wire        quarter_lead_in,
  input  wire        resolver_in,
  input  wire        enable_in,
  input  wire [15:0] gain_in,
  input  wire [15:0] bias_in,
  input  wire [15:0] local_shift_in,
  input  wire [15:0] slew_rate_in,
  input  wire [15:0] carrier_in,
  // Results
  output wire [15:0] applied_shift_out,
  output reg  [15:0] wave_out
);
  reg  [15:0]        applied_q;
  reg  [39:0]        acc_q;
  reg  [15:0]        elec_q;
  reg  [15:0]        sine_q;
  wire [25:0]        step_inc;
  wire [39:0]        acc_sum;
  wire [15:0]        shift_sum;
  wire [15:0]        mech_angle;
  wire [6:0]         pp_eff;
  wire [22:0]        elec_full;
  wire [14:0]        half_pos;
  wire [15:0]        half_rest;
  wire [30:0]        parab;
  wire [15:0]        para_y;
  wire [31:0]        corr_prod;
  wire [15:0]        corr_k;
  wire [31:0]        sine_prod;
  wire [14:0]        sine_mag;
  wire signed [32:0] scaled;
  wire signed [15:0] envelope;
  wire signed [17:0] biased;
  reg  signed [15:0] clamped;
  wire signed [31:0] modulated;
  wire [15:0]        mod_val;

  assign applied_shift_out = applied_q;

  // Slew the applied shift by one angle step each time the rate accumulator overflows.
  assign step_inc = {10'h000, slew_rate_in} * `SCG_RATE_FULL_DPS;
  assign acc_sum  = acc_q + {14'h0000, step_inc};

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      applied_q <= `SCG_PRM_RST;
      acc_q     <= 40'h00_0000_0000;
    end else if (slew_rate_in == 16'h0000) begin
      applied_q <= local_shift_in; // [RULE8] [RULE6]
      acc_q     <= 40'h00_0000_0000;
    end else if (applied_q == local_shift_in) begin
      acc_q     <= 40'h00_0000_0000;
    end else if (acc_sum >= SLEW_THRESH) begin
      acc_q     <= acc_sum - SLEW_THRESH; // [RULE7] [RULE8]
      if ($signed(local_shift_in) > $signed(applied_q)) begin
        applied_q <= applied_q + 16'h0001;
      end else begin
        applied_q <= applied_q - 16'h0001;
      end
    end else begin
      acc_q     <= acc_sum;
    end
  end

  // Mechanical angle plus shifts, scaled by pole pairs; all sums wrap at one revolution.
  assign shift_sum  = applied_q + (use_global_in ? global_angle_shift_in : 16'h0000); // [RULE12] [RULE13] [RULE14]
  assign mech_angle = rotor_angle_in + shift_sum; // [RULE11] [RULE17]
  assign pp_eff     = (pole_pairs_in == 7'h00) ? 7'h01 :
                      (pole_pairs_in > `SCG_PP_MAX) ? `SCG_PP_MAX : pole_pairs_in;
  assign elec_full  = mech_angle * pp_eff; // [RULE10]

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      elec_q <= 16'h0000;
    end else begin
      elec_q <= elec_full[15:0] + (quarter_lead_in ? `SCG_QUARTER : 16'h0000); // [RULE1] [RULE17]
    end
  end

  // Parabolic sine with a second-order correction; error stays near 0.1 percent of full scale.
  assign half_pos  = elec_q[14:0];
  assign half_rest = `SCG_HALF - {1'b0, half_pos};
  assign parab     = half_pos * half_rest;
  assign para_y    = parab[28:13];
  assign corr_prod = `SCG_SIN_K1 * para_y;
  assign corr_k    = `SCG_SIN_K0 + corr_prod[30:15];
  assign sine_prod = para_y * corr_k;
  assign sine_mag  = sine_prod[30] ? 15'h7fff : sine_prod[29:15];

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      sine_q <= 16'h0000;
    end else if (elec_q[15]) begin
      sine_q <= 16'h0000 - {1'b0, sine_mag};
    end else begin
      sine_q <= {1'b0, sine_mag};
    end
  end

  // Gain, bias and saturation, then the optional carrier multiplier.
  assign scaled   = $signed(sine_q) * $signed({1'b0, gain_in}); // [RULE3]
  assign envelope = scaled[31:16];
  assign biased   = {{2{envelope[15]}}, envelope} +
                    (resolver_in ? 18'sh00000 : {{2{bias_in[15]}}, bias_in}); // [RULE4] [RULE18]

  always @* begin
    if (biased > `SCG_Q15_POS) begin
      clamped = 16'sh7fff; // [RULE5]
    end else if (biased < `SCG_Q15_NEG) begin
      clamped = 16'sh8000; // [RULE5]
    end else begin
      clamped = biased[15:0];
    end
  end

  // Both factors at -1.0 would give +1.0, which does not fit, so that one case saturates.
  assign modulated = clamped * $signed(carrier_in); // [RULE2]
  assign mod_val   = (modulated[31:30] == 2'b01) ? 16'h7fff : modulated[30:15];

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      wave_out <= 16'h0000;
    end else if (!enable_in) begin
      wave_out <= 16'h0000;
    end else if (resolver_in) begin
      wave_out <= mod_val; // [RULE2]
    end else begin
      wave_out <= clamped;
    end
  end
endmodule

module scg_sincos_gen #(
  parameter [39:0] SLEW_THRESH = `SCG_SLEW_THRESH
) (
  // Clock and reset
  input  wire                   sys_clk_in,
  input  wire                   resetn_in,
  // Avalon-MM register slave
  input  wire [`SCG_ADDR_W-1:0] avs_address_in,
  input  wire                   avs_read_in,
  input  wire                   avs_write_in,
  input  wire [31:0]            avs_writedata_in,
  input  wire [3:0]             avs_byteenable_in,
  output reg  [31:0]            avs_readdata_out,
  output wire                   avs_waitrequest_out,
  // Angle sources and resolver carrier
  input  wire [15:0]            rotor_angle_in,
  input  wire [15:0]            global_angle_shift_in,
  input  wire [15:0]            resolver_carrier_in,
  // Generator outputs to the output multiplexer
  output wire [15:0]            sin_wave_out,
  output wire [15:0]            cos_wave_out
);
  reg  [1:0]  mode_q;
  reg         use_global_q;
  reg  [6:0]  pole_pairs_q;
  reg  [3:0]  chan_count_q;
  reg  [15:0] prm_q [0:7];
  reg         ack_q;
  reg  [31:0] rd_mux;
  wire        req;
  wire        wr_go;
  wire        prm_hit;
  wire [2:0]  prm_idx;
  wire        is_res;
  wire [1:0]  chan_en;
  wire [31:0] shift_w;
  wire [31:0] wave_w;
  genvar      gi;
  integer     pi;

  // One wait state on every access: the request is answered on the second cycle it is held.
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_go               = avs_write_in & ack_q;
  assign prm_hit             = (avs_address_in >= `SCG_REG_SIN_GAIN) && (avs_address_in <= `SCG_REG_COS_RATE);
  assign prm_idx             = avs_address_in[4:2] - 3'h1;

  always @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      mode_q       <= `SCG_MODE_RST;
      use_global_q <= 1'b0;
      pole_pairs_q <= `SCG_PP_RST;
      chan_count_q <= `SCG_CNT_RST;
    end else if (wr_go && (avs_address_in == `SCG_REG_CTRL)) begin
      if (avs_byteenable_in[0]) begin
        mode_q       <= avs_writedata_in[`SCG_CTRL_MODE_LSB +: 2];
        use_global_q <= avs_writedata_in[`SCG_CTRL_SRC_BIT];
      end
      if (avs_byteenable_in[1]) begin
        pole_pairs_q <= avs_writedata_in[`SCG_CTRL_PP_LSB +: 7];
      end
      if (avs_byteenable_in[2]) begin
        chan_count_q <= avs_writedata_in[`SCG_CTRL_CNT_LSB +: 4];
      end
    end
  end

  // One process owns the whole parameter array, so every word has a single driver.
  always @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      for (pi = 0; pi < 8; pi = pi + 1) begin
        prm_q[pi] <= `SCG_PRM_RST;
      end
    end else if (wr_go && prm_hit) begin
      if (avs_byteenable_in[0]) begin
        prm_q[prm_idx][7:0] <= avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        prm_q[prm_idx][15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    if (prm_hit) begin
      rd_mux = {16'h0000, prm_q[prm_idx]};
    end else if (avs_address_in == `SCG_REG_CTRL) begin
      rd_mux = {12'h000, chan_count_q, 1'b0, pole_pairs_q, 5'h00, use_global_q, mode_q};
    end else if (avs_address_in == `SCG_REG_SHIFT_STAT) begin
      rd_mux = shift_w;
    end else if (avs_address_in == `SCG_REG_WAVE) begin
      rd_mux = wave_w;
    end
  end

  // Read data is captured on the wait cycle and stands while waitrequest is low.
  always @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_q) begin
      avs_readdata_out <= rd_mux;
    end
  end

  // The channel count field is kept for software but never limits the two-channel modes.
  assign is_res  = (mode_q == `SCG_MODE_RES);
  assign chan_en = (mode_q == `SCG_MODE_ARB) ? 2'b01 : // [RULE16]
                   ((mode_q == `SCG_MODE_ENC) || is_res) ? 2'b11 : 2'b00; // [RULE15] [RULE1]

  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
      scg_chan #(
        .SLEW_THRESH (SLEW_THRESH)
      ) u_chan (
        .clk_in                (sys_clk_in),
        .resetn_in             (resetn_in),
        .rotor_angle_in        (rotor_angle_in),
        .global_angle_shift_in (global_angle_shift_in),
        .use_global_in         (use_global_q),
        .pole_pairs_in         (pole_pairs_q),
        .quarter_lead_in       (gi == 1),
        .resolver_in           (is_res),
        .enable_in             (chan_en[gi]),
        .gain_in               (prm_q[4*gi + `SCG_SLOT_GAIN]),
        .bias_in               (prm_q[4*gi + `SCG_SLOT_BIAS]),
        .local_shift_in        (prm_q[4*gi + `SCG_SLOT_SHIFT]),
        .slew_rate_in          (prm_q[4*gi + `SCG_SLOT_RATE]),
        .carrier_in            (resolver_carrier_in),
        .applied_shift_out     (shift_w[16*gi +: 16]),
        .wave_out              (wave_w[16*gi +: 16])
      );
    end
  endgenerate

  assign sin_wave_out = wave_w[15:0];
  assign cos_wave_out = wave_w[31:16];
endmodule

/* bench/scg_mux_model.sv */
// Output multiplexer stand-in that takes both channels and supplies the resolver carrier.
`timescale 1ns/1ps
module scg_mux_model (
  // Clock and carrier level
  input  wire        clk_in,
  input  wire [15:0] level_in,
  // Generator channels and carrier
  input  wire [15:0] sin_in,
  input  wire [15:0] cos_in,
  output reg  [15:0] carrier_out
);
  // A converter clocks its carrier, so the sample is registered, not passed through.
  always @(posedge clk_in) begin
    carrier_out <= level_in;
  end
endmodule

/* bench/scg_sincos_gen_chk.sv */
// Port-level assertions for the sine/cosine generator.
`timescale 1ns/1ps
`include "scg_defs.vh"
module scg_sincos_gen_chk (
  // Clock, reset and register bus
  input wire        sys_clk_in,
  input wire        resetn_in,
  input wire [5:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0]  avs_byteenable_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  // Generator outputs
  input wire [15:0] sin_wave_out,
  input wire [15:0] cos_wave_out
);
  wire       req = avs_read_in | avs_write_in;
  wire       done = req & ~avs_waitrequest_out;
  reg  [1:0] mode_q;
  reg        quiet_q;
  // Until the first write, gain and bias are zero, so both outputs must rest at zero.
  always @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      mode_q <= `SCG_MODE_RST;
      quiet_q <= 1'b1;
    end else if (done && avs_write_in) begin
      quiet_q <= 1'b0;
      if (avs_address_in == `SCG_REG_CTRL && avs_byteenable_in[0]) begin
        mode_q <= avs_writedata_in[1:0];
      end
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("new request answered without a wait state");
  a_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request kept waiting past one cycle");
  a_idle_ready: assert property (!req |-> !avs_waitrequest_out)
    else $error("wait raised with no request");
  a_wave_read: assert property (done && avs_read_in && avs_address_in == `SCG_REG_WAVE
    |-> avs_readdata_out == $past({cos_wave_out, sin_wave_out}))
    else $error("wave register differs from outputs");
  a_unmapped_zero: assert property (done && avs_read_in && avs_address_in > `SCG_REG_WAVE |-> avs_readdata_out == 0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (quiet_q |-> sin_wave_out == 0 && cos_wave_out == 0)
    else $error("output moved with zero gain");
  a_arb_cos_zero: assert property ((mode_q == `SCG_MODE_ARB) [*4] |-> cos_wave_out == 0)
    else $error("second channel active in single generator mode");
  a_off_zero: assert property ((mode_q == 2'h3) [*4] |-> sin_wave_out == 0 && cos_wave_out == 0)
    else $error("output active while switched off");
  cover property (done && avs_write_in);
  cover property (done && avs_read_in && avs_address_in == `SCG_REG_WAVE);
  cover property ((mode_q == `SCG_MODE_RES) [*4]);
endmodule
bind scg_sincos_gen scg_sincos_gen_chk CHK (
  .sys_clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .sin_wave_out, .cos_wave_out
);

/* bench/scg_sincos_gen_test.sv */
// Self-checking bench for the sine/cosine generator.
`timescale 1ns/1ps
`include "scg_defs.vh"
module scg_sincos_gen_test;
  typedef struct {
    logic [31:0] ctrl;
    logic [15:0] gain, bias, shift, rotor, glob;
    int          xs, xc;
  } scg_row_t;
  localparam int TOL = 80;
  logic        sys_clk_in, resetn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [5:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdq;
  logic [15:0] rotor_angle_in, global_angle_shift_in, resolver_carrier_in, sin_wave_out, cos_wave_out;
  int          err_total, compares;
  scg_row_t    r;
  // The last two columns are ideal sine values; the design's sine is approximate, hence TOL.
  scg_row_t    rows [11] = '{
    '{32'h100, 16'hffff, 16'h0, 16'h0, 16'h4000, 16'h0, 32766, 0},
    '{32'h400, 16'hffff, 16'h0, 16'h0, 16'h1000, 16'h0, 32766, 0},
    '{32'h7f00, 16'h8000, 16'h0, 16'h0, 16'h0100, 16'h0, 16383, 0},
    '{32'h100, 16'hffff, 16'h4000, 16'h0, 16'h4000, 16'h0, 32767, 16384},
    '{32'h100, 16'hffff, 16'hc000, 16'h0, 16'hc000, 16'h0, -32768, -16384},
    '{32'h104, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h4000, 32766, 0},
    '{32'h100, 16'hffff, 16'h0, 16'h0, 16'h0, 16'h4000, 0, 32766},
    '{32'h100, 16'hffff, 16'h0, 16'h8000, 16'hc000, 16'h0, 32766, 0},
    '{32'hf0101, 16'hffff, 16'h4000, 16'h0, 16'h4000, 16'h0, 16383, 0},
    '{32'h102, 16'h8000, 16'h2000, 16'h0, 16'h2000, 16'h0, 19777, 0},
    '{32'h103, 16'hffff, 16'h0, 16'h0, 16'h4000, 16'h0, 0, 0}
  };

  scg_mux_model MUX (.clk_in(sys_clk_in), .level_in(16'h4000), .sin_in(sin_wave_out),
    .cos_in(cos_wave_out), .carrier_out(resolver_carrier_in));
  // A short slew threshold makes rate 1 step the applied shift every second clock.
  scg_sincos_gen #(.SLEW_THRESH(40'd2000)) DUT (
    .sys_clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in(4'hf), .avs_readdata_out, .avs_waitrequest_out, .rotor_angle_in,
    .global_angle_shift_in, .resolver_carrier_in, .sin_wave_out, .cos_wave_out
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task print_verdict;
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic signed [31:0] seen, input logic signed [31:0] exp, input int tol);
    compares++;
    if ($isunknown(seen) || (tol == 0 && seen !== exp) || seen - exp > tol || exp - seen > tol) begin
      err_total++;
      $display("BAD %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask

  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= a;
    avs_writedata_in <= d;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 64);
    rdq = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (n >= 64) begin
      err_total++;
      print_verdict();
    end
  endtask

  initial begin
    resetn_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 6'h0;
    avs_writedata_in = 32'h0;
    rotor_angle_in = 16'h0;
    global_angle_shift_in = 16'h0;
    err_total = 0;
    compares = 0;
    repeat (20) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      rotor_angle_in <= r.rotor;
      global_angle_shift_in <= r.glob;
      bus(1'b1, `SCG_REG_CTRL, r.ctrl);
      for (int k = 0; k < 2; k++) begin
        bus(1'b1, 6'(4 + 16 * k), {16'h0, r.gain});
        bus(1'b1, 6'(8 + 16 * k), {16'h0, r.bias});
        bus(1'b1, 6'(12 + 16 * k), {16'h0, r.shift});
      end
      repeat (8) @(posedge sys_clk_in);
      check($signed(sin_wave_out), r.xs, TOL);
      check($signed(cos_wave_out), r.xc, TOL);
      bus(1'b0, `SCG_REG_WAVE, 32'h0);
      check($signed(rdq[15:0]), r.xs, TOL);
      check($signed(rdq[31:16]), r.xc, TOL);
    end
    // Unmapped and read-only places swallow writes.
    bus(1'b1, 6'h3c, 32'hffffffff);
    bus(1'b0, 6'h3c, 32'h0);
    check(rdq, 32'h0, 0);
    bus(1'b1, `SCG_REG_SHIFT_STAT, 32'hffffffff);
    bus(1'b1, `SCG_REG_SIN_GAIN, 32'hffffbeef);
    bus(1'b0, `SCG_REG_SIN_GAIN, 32'h0);
    check(rdq, 32'hbeef, 0);
    bus(1'b1, `SCG_REG_SIN_RATE, 32'h1);
    bus(1'b1, `SCG_REG_SIN_SHIFT, 32'h10);
    bus(1'b1, `SCG_REG_COS_SHIFT, 32'h20);
    bus(1'b0, `SCG_REG_SHIFT_STAT, 32'h0);
    // Rate 1 against the short threshold steps once per two clocks; four clocks pass before the read.
    check(rdq[15:0], 16'h0002, 0);
    check(rdq[31:16], 16'h20, 0);
    repeat (40) @(posedge sys_clk_in);
    bus(1'b0, `SCG_REG_SHIFT_STAT, 32'h0);
    check(rdq, 32'h00200010, 0);
    resetn_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    bus(1'b0, `SCG_REG_CTRL, 32'h0);
    check(rdq, 32'h00020100, 0);
    check(sin_wave_out, 16'h0, 0);
    print_verdict();
  end
endmodule
